/* File: bench/boot_loader_self_programming_tb_top.sv */
// self-checking bench for the self-programming sequencer
`timescale 1ns/1ns
module boot_loader_self_programming_tb_top;
  localparam logic [13:0] IN_BOOT = 14'h3f80;
  localparam logic [15:0] PAGE_Z  = 16'h0280;
  localparam int          LONG    = self_prog_pkg::PROG_TIME_NS / self_prog_pkg::CLK_PERIOD_NS;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        store_program_instr;
  logic        load_program_instr;
  logic [13:0] instr_addr;
  logic [15:0] z_pointer;
  logic [7:0]  data_low_reg;
  logic [7:0]  data_high_reg;
  logic [7:0]  read_data;
  logic        read_valid;
  logic        cpu_halt;
  logic [13:0] reset_vector;
  logic [1:0]  boot_size_fuse = 2'h2;
  logic        boot_reset_fuse = 1'b1;
  logic [31:0] q;
  int          mismatches = 0;
  int          cmp_count = 0;
  int          i;

  always #4 clk = ~clk;

  boot_loader_self_programming boot_loader_self_programming_inst (
    .clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .store_program_instr,
    .load_program_instr, .instr_addr, .z_pointer, .data_low_reg, .data_high_reg,
    .read_data, .read_valid, .cpu_halt, .reset_vector, .boot_size_fuse, .boot_reset_fuse
  );
  cpu_core_model cpu_core_model_inst (
    .clk, .store_program_instr, .load_program_instr, .instr_addr, .z_pointer,
    .data_low_reg, .data_high_reg
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic hang();
    mismatches++;
    $display("ERROR t=%0t seen=%h exp=%h", $time, 32'h0, 32'h1);
    final_report();
  endtask

  // one register access; holds the request until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) hang();
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(q, exp);
  endtask

  // counts halted cycles after a store; the core issues nothing meanwhile
  task automatic wait_prog(input int exp);
    int n;
    int hc;
    hc = 0;
    for (n = 0; n < 400; n++) begin
      @(negedge clk);
      if (cpu_halt === 1'b1) hc++;
      else if (n > 2) break;
    end
    if (n == 400) hang();
    check(32'(hc), 32'(exp));
    @(posedge clk);
  endtask

  task automatic rdb(input logic [15:0] z, input logic [7:0] exp);
    int n;
    cpu_core_model_inst.issue(1'b0, IN_BOOT, z, 16'h0);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (read_valid !== 1'b1 && n < 8);
    if (read_valid !== 1'b1) hang();
    check(32'(read_data), 32'(exp));
    @(posedge clk);
  endtask

  task automatic store(input logic [13:0] ia, input logic [15:0] z, input logic [15:0] d);
    cpu_core_model_inst.issue(1'b1, ia, z, d);
  endtask

  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    rdchk(self_prog_pkg::CTRL_OFS, 32'h0);
    rdchk(self_prog_pkg::LOCK_OFS, 32'hf);
    rdchk(4'h2, 32'h0);
    rdchk(self_prog_pkg::STATUS_OFS, 32'h3e00000c);
    bus(1'b1, self_prog_pkg::STATUS_OFS, 32'hffffffff);
    rdchk(self_prog_pkg::STATUS_OFS, 32'h3e00000c);
    $display("test registers done");
    // every size code, then the application reset choice
    for (i = 0; i < 5; i++) begin
      @(posedge clk);
      boot_size_fuse <= (i < 4) ? 2'(i) : 2'h2;
      boot_reset_fuse <= (i < 4);
      repeat (5) @(negedge clk);
      check(32'(reset_vector), (i < 4) ? 32'h4000 - (32'h100 << (3 - i)) : 32'h0);
    end
    @(posedge clk);
    boot_reset_fuse <= 1'b1;
    $display("test fuses done");
    // erase a boot page from boot code
    bus(1'b1, self_prog_pkg::CTRL_OFS, 32'h3);
    store(IN_BOOT, 16'h7f80, 16'h0);
    wait_prog(LONG);
    rdb(16'h7f80, 8'hff);
    // erase, fill in reverse order, write the same page
    bus(1'b1, self_prog_pkg::CTRL_OFS, 32'h3);
    store(IN_BOOT, PAGE_Z | 16'h7f, 16'h1234);
    wait_prog(LONG);
    rdchk(self_prog_pkg::CTRL_OFS, 32'h0);
    rdb(PAGE_Z | 16'h4, 8'hff);
    for (i = 63; i >= 0; i--) begin
      bus(1'b1, self_prog_pkg::CTRL_OFS, 32'h1);
      store(IN_BOOT, PAGE_Z | 16'(i << 1), 16'h5a00 | 16'(i));
    end
    bus(1'b1, self_prog_pkg::CTRL_OFS, 32'h5);
    store(IN_BOOT, PAGE_Z, 16'hbeef);
    wait_prog(LONG);
    for (i = 0; i < 64; i++) begin
      rdb(PAGE_Z | 16'(2 * i), 8'(i));
      rdb(PAGE_Z | 16'(2 * i + 1), 8'h5a);
    end
    $display("test page update done");
    // store from the application section and a late store both do nothing
    bus(1'b1, self_prog_pkg::CTRL_OFS, 32'h3);
    store(14'h0100, PAGE_Z, 16'h0);
    wait_prog(0);
    bus(1'b1, self_prog_pkg::CTRL_OFS, 32'h3);
    repeat (5) @(posedge clk);
    store(IN_BOOT, PAGE_Z, 16'h0);
    wait_prog(0);
    rdb(PAGE_Z | 16'h1, 8'h5a);
    $display("test refusals done");
    // lock write at the last cycle of the window, then read back
    bus(1'b1, self_prog_pkg::CTRL_OFS, 32'h9);
    repeat (3) @(posedge clk);
    store(IN_BOOT, 16'h0001, 16'h00d7);
    wait_prog(LONG);
    rdchk(self_prog_pkg::LOCK_OFS, 32'h5);
    bus(1'b1, self_prog_pkg::CTRL_OFS, 32'h9);
    rdb(16'h0001, 8'hd7);
    // re-enable the application section; busy flag stays clear
    bus(1'b1, self_prog_pkg::CTRL_OFS, 32'h11);
    store(IN_BOOT, 16'h0, 16'h0);
    wait_prog(0);
    rdchk(self_prog_pkg::CTRL_OFS, 32'h0);
    $display("test locks done");
    final_report();
  end
endmodule

/* File: bench/cpu_core_model.sv */
// processor core model issuing store-program and load-program instructions
`timescale 1ns/1ns
module cpu_core_model (
  input  wire logic        clk,
  output logic             store_program_instr,
  output logic             load_program_instr,
  output logic      [13:0] instr_addr,
  output logic      [15:0] z_pointer,
  output logic      [7:0]  data_low_reg,
  output logic      [7:0]  data_high_reg
);
  initial begin
    store_program_instr = 1'b0;
    load_program_instr = 1'b0;
    instr_addr = 14'h0;
    z_pointer = 16'h0;
    {data_high_reg, data_low_reg} = 16'h0;
  end

  // one instruction, entered just after a rising edge
  task automatic issue(input logic st, input logic [13:0] ia, input logic [15:0] z,
                       input logic [15:0] d);
    store_program_instr <= st;
    load_program_instr <= ~st;
    instr_addr <= ia;
    z_pointer <= z;
    {data_high_reg, data_low_reg} <= d;
    @(posedge clk);
    store_program_instr <= 1'b0;
    load_program_instr <= 1'b0;
    // operands are dead now, so drive their complements
    z_pointer <= ~z;
    {data_high_reg, data_low_reg} <= ~d;
  endtask
endmodule

/* File: bench/self_prog_monitor.sv */
// port assertions for the self-programming sequencer
`timescale 1ns/1ns
module self_prog_monitor (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic        store_program_instr,
  input wire logic        load_program_instr,
  input wire logic [13:0] instr_addr,
  input wire logic        read_valid,
  input wire logic        cpu_halt,
  input wire logic [13:0] reset_vector,
  input wire logic [1:0]  boot_size_fuse,
  input wire logic        boot_reset_fuse
);
  logic [13:0] boot_base;
  logic [8:0]  halt_cnt;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // boot start worked out from the raw fuse pins
  assign boot_base = ~((14'h100 << (2'h3 - boot_size_fuse)) - 14'h1);

  // length of the current halt, zero when running
  always_ff @(posedge clk) begin
    if (reset || !cpu_halt) halt_cnt <= 9'h0;
    else halt_cnt <= halt_cnt + 9'h1;
  end

  property p_wait_answer;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("bus answer late");
  property p_wait_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
  property p_halt_cause;
    $rose(cpu_halt) |-> $past(store_program_instr) && $past(instr_addr) >= boot_base;
  endproperty
  a_halt_cause: assert property (p_halt_cause) else $error("halt without store");
  property p_halt_len;
    $fell(cpu_halt) |-> halt_cnt == 9'hfa;
  endproperty
  a_halt_len: assert property (p_halt_len) else $error("halt length wrong");
  property p_halt_max;
    halt_cnt <= 9'hfa;
  endproperty
  a_halt_max: assert property (p_halt_max) else $error("halt overruns");
  property p_outside;
    store_program_instr && instr_addr < boot_base |=> !$rose(cpu_halt);
  endproperty
  a_outside: assert property (p_outside) else $error("store outside boot acted");
  property p_read_ans;
    load_program_instr && !cpu_halt |-> ##[1:2] read_valid;
  endproperty
  a_read_ans: assert property (p_read_ans) else $error("read not answered");
  property p_valid_pulse;
    read_valid |=> !read_valid;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("read_valid too long");
  property p_vector;
    ($stable(boot_size_fuse) && $stable(boot_reset_fuse))[*4]
      |-> reset_vector == (boot_reset_fuse ? boot_base : 14'h0);
  endproperty
  a_vector: assert property (p_vector) else $error("reset vector wrong");
endmodule

bind boot_loader_self_programming self_prog_monitor self_prog_monitor_inst (
  .clk, .reset, .avs_read, .avs_write, .avs_waitrequest, .store_program_instr,
  .load_program_instr, .instr_addr, .read_valid, .cpu_halt, .reset_vector,
  .boot_size_fuse, .boot_reset_fuse
);

/* File: hdl/boot_loader_self_programming.sv */
// self-programming sequencer: command arming, page buffer, erase and write of program flash
//
// Behaviour
// [R1] store-program acts only when fetched from the boot section; target anywhere.
// [R2] flash is 256 pages of 64 words, reprogrammed whole pages only.
// [R3] boot section at top of flash, size from the two-bit size fuse.
// [R4] reset vector is 0000 or the boot start, chosen by the reset fuse.
// [R5] the processor has no path to change any fuse.
// [R6] boot code may erase and write every page, boot pages included.
// [R7] general write and read locks never gate self-programming or reads.
// [R8] software erases before writing and reloads unchanged words into the buffer.
// [R9] buffer words may be loaded in any order.
// [R10] command 00011 plus store within four cycles erases page Z14:Z7.
// [R11] command 00001 plus store loads data pair into buffer slot Z6:Z1.
// [R12] command 00101 plus store writes buffer into page Z14:Z7.
// [R13] software uses the same page for erase and following write.
// [R14] processor halted during erase, write, lock write; enable bit cleared after.
// [R15] software follows long operations with word FFFF and a no-op.
// [R16] software avoids reading application section while erase or write runs.
// [R17] software re-enables the application section and checks the busy flag.
// [R18] app busy flag and re-enable bit have no function; busy reads zero.
// [R19] software should disable interrupts during erase or write.
// [R20] software should protect the boot section with its lock bit.
// [R21] armed command clears unless store within four or read within five.
// [R22] command 01001 plus store programs lock bits given by zeros in data.
// [R23] store with no armed command or outside boot section does nothing.
// [R24] processor stalled a fixed count while programming, then released.
//
// Local design decisions: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module boot_loader_self_programming (
  input  wire logic        clk,
  input  wire logic        reset,
  // register bus
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // processor side
  input  wire logic        store_program_instr,
  input  wire logic        load_program_instr,
  input  wire logic [13:0] instr_addr,
  input  wire logic [15:0] z_pointer,
  input  wire logic [7:0]  data_low_reg,
  input  wire logic [7:0]  data_high_reg,
  output logic      [7:0]  read_data,
  output logic             read_valid,
  output logic             cpu_halt,
  output logic      [13:0] reset_vector,
  // fuse pins
  input  wire logic [1:0]  boot_size_fuse,
  input  wire logic        boot_reset_fuse
);
  typedef enum logic [2:0] {
    st_idle,
    st_armed,
    st_erase,
    st_write,
    st_lock
  } seq_state_t;

  typedef struct packed {
    seq_state_t                        state;
    logic [self_prog_pkg::CMD_W-1:0]   cmd;
    logic [2:0]                        age;
    logic [self_prog_pkg::PAGE_W-1:0]  page;
    logic [self_prog_pkg::IDX_W-1:0]   idx;
    logic                              walked;
    logic [self_prog_pkg::CNT_W-1:0]   cnt;
    logic [63:0][15:0]                 buffer;
    logic [3:0]                        locks;
    logic [1:0]                        size_meta;
    logic [1:0]                        size_sync;
    logic                              rst_meta;
    logic                              rst_sync;
    logic                              read_pend;
    logic                              read_hi;
    logic [7:0]                        read_data;
    logic                              read_valid;
    logic                              halt;
    logic [13:0]                       reset_vector;
    logic                              wait_req;
    logic [31:0]                       rdata;
  } top_state_t;

  top_state_t   s;
  top_state_t   next_s;
  logic [13:0]  boot_start;
  logic [13:0]  map_vector;
  logic         fetch_in_boot;
  logic         bus_req;
  logic         bus_done;
  logic         ctrl_wr;
  logic         store_ok;
  logic         read_ok;
  logic         fl_wr_en;
  logic [13:0]  fl_wr_addr;
  logic [15:0]  fl_wr_data;
  logic         fl_rd_en;
  logic [13:0]  fl_rd_addr;

  flash_port_if fport ();

  flash_store u_flash (
    .clk   (clk),
    .reset (reset),
    .port  (fport.mem)
  );

  // fuses come only from pins; nothing on the bus can write them
  boot_map u_map (
    .boot_size_fuse  (s.size_sync),
    .boot_reset_fuse (s.rst_sync),
    .fetch_addr      (instr_addr),
    .boot_start      (boot_start),
    .reset_vector    (map_vector),
    .fetch_in_boot   (fetch_in_boot)
  ); // see [R3] see [R5]

  assign fport.wr_en   = fl_wr_en;
  assign fport.wr_addr = fl_wr_addr;
  assign fport.wr_data = fl_wr_data;
  assign fport.rd_en   = fl_rd_en;
  assign fport.rd_addr = fl_rd_addr;

  // register read mux; app busy flag always reads zero
  function automatic logic [31:0] reg_read(input logic [3:0] addr, input top_state_t st,
                                           input logic [13:0] start);
    logic [31:0] val;
    val = 32'h0000_0000;
    unique case (addr)
      self_prog_pkg::CTRL_OFS:   val = {27'h0, st.cmd}; // see [R18]
      self_prog_pkg::STATUS_OFS: val = {2'h0, start, 12'h000, st.rst_sync, st.size_sync,
                                        st.halt};
      self_prog_pkg::LOCK_OFS:   val = {28'h0, st.locks};
      self_prog_pkg::PAGE_OFS:   val = {18'h0, st.page, st.idx};
      default:                   val = 32'h0000_0000;
    endcase
    return val;
  endfunction

  // bus handshake: one wait cycle, the answer cycle has waitrequest low
  assign bus_req  = avs_read || avs_write;
  assign bus_done = avs_write && !s.wait_req;
  // control writes are refused while the processor is halted
  assign ctrl_wr  = bus_done && (avs_address == self_prog_pkg::CTRL_OFS)
                    && avs_byteenable[0] && (s.state inside {st_idle, st_armed});
  // store only counts from boot code inside the window
  assign store_ok = store_program_instr && fetch_in_boot
                    && (s.age < self_prog_pkg::ARM_STORE_CYCLES); // see [R1] see [R10]
  assign read_ok  = load_program_instr && (s.age < self_prog_pkg::ARM_READ_CYCLES);

  always_comb begin
    next_s     = s;
    fl_wr_en   = 1'b0;
    fl_wr_addr = {s.page, s.idx};
    fl_wr_data = self_prog_pkg::ERASED_WORD;
    fl_rd_en   = 1'b0;
    fl_rd_addr = z_pointer[self_prog_pkg::Z_PAGE_HI:self_prog_pkg::Z_IDX_LO];

    // bus slave
    next_s.wait_req = !(bus_req && s.wait_req);
    if (bus_req && s.wait_req) begin
      next_s.rdata = reg_read(avs_address, s, boot_start);
    end

    // fuse pins pass two flops before use
    next_s.size_meta    = boot_size_fuse;
    next_s.size_sync    = s.size_meta;
    next_s.rst_meta     = boot_reset_fuse;
    next_s.rst_sync     = s.rst_meta;
    next_s.reset_vector = map_vector; // see [R4]

    // program memory read return, byte picked by Z0
    next_s.read_valid = 1'b0;
    next_s.read_pend  = 1'b0;
    if (s.read_pend) begin
      next_s.read_valid = 1'b1;
      next_s.read_data  = s.read_hi ? fport.rd_data[15:8] : fport.rd_data[7:0];
    end

    unique case (s.state)
      st_idle: begin
        // plain reads ignore every lock bit
        if (load_program_instr) begin
          fl_rd_en         = 1'b1;
          next_s.read_pend = 1'b1;
          next_s.read_hi   = z_pointer[self_prog_pkg::Z_BYTE];
        end // see [R7]
        if (ctrl_wr) begin
          next_s.cmd = avs_writedata[self_prog_pkg::CMD_W-1:0];
          next_s.age = 3'h0;
          if (avs_writedata[self_prog_pkg::ENABLE_BIT]) begin
            next_s.state = st_armed;
          end
        end
      end

      st_armed: begin
        next_s.age = s.age + 3'h1;
        if (store_ok) begin
          unique case (s.cmd)
            self_prog_pkg::CMD_PAGE_ERASE: begin
              next_s.state  = st_erase;
              next_s.page   = z_pointer[self_prog_pkg::Z_PAGE_HI:self_prog_pkg::Z_PAGE_LO];
              next_s.idx    = '0;
              next_s.walked = 1'b0;
              next_s.cnt    = '0;
              next_s.halt   = 1'b1;
            end // see [R10] see [R6] see [R14]
            self_prog_pkg::CMD_PAGE_WRITE: begin
              next_s.state  = st_write;
              next_s.page   = z_pointer[self_prog_pkg::Z_PAGE_HI:self_prog_pkg::Z_PAGE_LO];
              next_s.idx    = '0;
              next_s.walked = 1'b0;
              next_s.cnt    = '0;
              next_s.halt   = 1'b1;
            end // see [R12] see [R6] see [R14]
            self_prog_pkg::CMD_BUF_LOAD: begin
              // any slot, any order; no halt needed
              next_s.buffer[z_pointer[self_prog_pkg::Z_IDX_HI:self_prog_pkg::Z_IDX_LO]] =
                {data_high_reg, data_low_reg}; // see [R11] see [R9]
              next_s.cmd   = '0;
              next_s.state = st_idle;
            end
            self_prog_pkg::CMD_LOCK_SET: begin
              // lock bits only ever move toward programmed
              next_s.locks = s.locks &
                data_low_reg[self_prog_pkg::LOCK_DATA_HI:self_prog_pkg::LOCK_DATA_LO];
              next_s.state = st_lock;
              next_s.cnt   = '0;
              next_s.halt  = 1'b1;
            end // see [R22] see [R14]
            self_prog_pkg::CMD_APP_REEN: begin
              // kept for software compatibility only
              next_s.cmd   = '0;
              next_s.state = st_idle;
            end // see [R18]
            default: begin
              next_s.state = st_armed;
            end // see [R23]
          endcase
        end else if (read_ok && s.cmd[self_prog_pkg::LOCK_SET_BIT]) begin
          // lock readback consumes the armed command
          next_s.read_data  = {self_prog_pkg::LOCK_PAD, s.locks, self_prog_pkg::LOCK_PAD};
          next_s.read_valid = 1'b1;
          next_s.cmd        = '0;
          next_s.state      = st_idle;
        end else begin
          // nothing came in the window: drop the command
          if (s.age == self_prog_pkg::ARM_READ_CYCLES - 3'h1) begin
            next_s.cmd   = '0;
            next_s.state = st_idle;
          end
          // a plain read is still served on the cycle the window closes
          if (load_program_instr) begin
            fl_rd_en         = 1'b1;
            next_s.read_pend = 1'b1;
            next_s.read_hi   = z_pointer[self_prog_pkg::Z_BYTE];
          end
        end // see [R21]
        // rewriting the command restarts the window
        if (ctrl_wr) begin
          next_s.cmd   = avs_writedata[self_prog_pkg::CMD_W-1:0];
          next_s.age   = 3'h0;
          next_s.state = avs_writedata[self_prog_pkg::ENABLE_BIT] ? st_armed : st_idle;
        end
      end

      st_erase, st_write: begin
        // walk all 64 words of the page, then sit out the rest of the stall time
        next_s.cnt = s.cnt + 9'h001;
        if (!s.walked) begin
          fl_wr_en   = 1'b1;
          fl_wr_data = (s.state == st_write) ? s.buffer[s.idx] : self_prog_pkg::ERASED_WORD;
          next_s.idx = s.idx + 6'h01;
          if (s.idx == self_prog_pkg::LAST_IDX) begin
            next_s.walked = 1'b1;
          end
        end // see [R2]
        if (s.cnt == self_prog_pkg::PROG_LAST) begin
          next_s.state = st_idle;
          next_s.cmd   = '0;
          next_s.halt  = 1'b0;
          if (s.state == st_write) begin
            next_s.buffer = '1;
          end
        end // see [R24] see [R14]
      end

      st_lock: begin
        next_s.cnt = s.cnt + 9'h001;
        if (s.cnt == self_prog_pkg::PROG_LAST) begin
          next_s.state = st_idle;
          next_s.cmd   = '0;
          next_s.halt  = 1'b0;
        end // see [R24] see [R14]
      end
    endcase
  end

  // single state register; buffer resets erased, locks unprogrammed
  always_ff @(posedge clk) begin
    if (reset) begin
      s          <= '0;
      s.wait_req <= 1'b1;
      s.locks    <= self_prog_pkg::LOCK_RESET;
      s.buffer   <= '1;
      s.size_meta <= 2'h0;
      s.reset_vector <= self_prog_pkg::APP_RESET_ADDR;
    end else begin
      s <= next_s;
    end
  end

  // every output straight from the state register
  assign avs_readdata    = s.rdata;
  assign avs_waitrequest = s.wait_req;
  assign read_data       = s.read_data;
  assign read_valid      = s.read_valid;
  assign cpu_halt        = s.halt;
  assign reset_vector    = s.reset_vector;
endmodule

/* File: hdl/boot_map.sv */
// boot section placement and reset vector from the fuses
`timescale 1ns/1ns
module boot_map (
  input  wire logic [1:0]  boot_size_fuse,
  input  wire logic        boot_reset_fuse,
  input  wire logic [13:0] fetch_addr,
  output logic      [13:0] boot_start,
  output logic      [13:0] reset_vector,
  output logic             fetch_in_boot
);
  // boot section always ends at the top word of flash
  always_comb begin
    boot_start    = self_prog_pkg::boot_start_of(boot_size_fuse);
    fetch_in_boot = (fetch_addr >= boot_start);
    reset_vector  = boot_reset_fuse ? self_prog_pkg::boot_start_of(boot_size_fuse)
                                    : self_prog_pkg::APP_RESET_ADDR;
  end
endmodule

/* File: hdl/flash_port_if.sv */
// word port between the sequencer and the flash array
`timescale 1ns/1ns
interface flash_port_if;
  logic        wr_en;
  logic [13:0] wr_addr;
  logic [15:0] wr_data;
  logic        rd_en;
  logic [13:0] rd_addr;
  logic [15:0] rd_data;
  modport ctrl (output wr_en, output wr_addr, output wr_data,
                output rd_en, output rd_addr, input rd_data);
  modport mem  (input wr_en, input wr_addr, input wr_data,
                input rd_en, input rd_addr, output rd_data);
endinterface

/* File: hdl/flash_store.sv */
// program flash array with one write and one registered read port
`timescale 1ns/1ns
module flash_store (
  input wire logic    clk,
  input wire logic    reset,
  flash_port_if.mem   port
);
  typedef struct packed {
    logic [15:0] rd_data;
  } flash_state_t;

  logic [15:0]  mem [self_prog_pkg::FLASH_WORDS];
  flash_state_t s;
  flash_state_t next_s;

  // array contents survive reset, as flash does
  always_ff @(posedge clk) begin
    if (port.wr_en) begin
      mem[port.wr_addr] <= port.wr_data;
    end
  end

  // read data appears one cycle after the request
  always_comb begin
    next_s = s;
    if (port.rd_en) begin
      next_s.rd_data = mem[port.rd_addr];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign port.rd_data = s.rd_data;
endmodule

/* File: hdl/self_prog_pkg.sv */
// shared constants, command codes and boot map decode for the self-programming block
package self_prog_pkg;
  // flash geometry: 256 pages of 64 sixteen-bit words
  localparam int          FLASH_AW    = 14;
  localparam int          FLASH_WORDS = 16384;
  localparam int          PAGE_W      = 8;
  localparam int          IDX_W       = 6;
  localparam logic [5:0]  LAST_IDX    = 6'h3f;
  localparam logic [15:0] ERASED_WORD = 16'hffff;

  // pointer fields
  localparam int Z_PAGE_HI = 14;
  localparam int Z_PAGE_LO = 7;
  localparam int Z_IDX_HI  = 6;
  localparam int Z_IDX_LO  = 1;
  localparam int Z_BYTE    = 0;

  // control register: command field and flag positions
  localparam int         CMD_W          = 5;
  localparam int         ENABLE_BIT     = 0;
  localparam int         LOCK_SET_BIT   = 3;
  localparam int         APP_BUSY_BIT   = 6;
  localparam logic [4:0] CMD_BUF_LOAD   = 5'h01;
  localparam logic [4:0] CMD_PAGE_ERASE = 5'h03;
  localparam logic [4:0] CMD_PAGE_WRITE = 5'h05;
  localparam logic [4:0] CMD_LOCK_SET   = 5'h09;
  localparam logic [4:0] CMD_APP_REEN   = 5'h11;

  // lock bits in the low data register, zero programs
  localparam int         LOCK_DATA_HI = 5;
  localparam int         LOCK_DATA_LO = 2;
  localparam logic [3:0] LOCK_RESET   = 4'hf;
  localparam logic [1:0] LOCK_PAD     = 2'h3;

  // arming windows in clock cycles
  localparam logic [2:0] ARM_STORE_CYCLES = 3'h4;
  localparam logic [2:0] ARM_READ_CYCLES  = 3'h5;

  // programming stall time
  localparam int         CLK_PERIOD_NS = 8;
  localparam int         PROG_TIME_NS  = 2000;
  localparam int         PROG_CYCLES   = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         CNT_W         = 9;
  localparam logic [8:0] PROG_LAST     = 9'(PROG_CYCLES - 1);

  // boot map
  localparam logic [13:0] APP_RESET_ADDR = 14'h0000;
  localparam logic [13:0] BOOT_START_256 = 14'h3f00;
  localparam logic [13:0] BOOT_START_512 = 14'h3e00;
  localparam logic [13:0] BOOT_START_1K  = 14'h3c00;
  localparam logic [13:0] BOOT_START_2K  = 14'h3800;

  // register byte offsets
  localparam logic [3:0] CTRL_OFS   = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] LOCK_OFS   = 4'h8;
  localparam logic [3:0] PAGE_OFS   = 4'hc;

  // boot section start from the two size fuse bits
  function automatic logic [13:0] boot_start_of(input logic [1:0] size_fuse);
    logic [13:0] start;
    unique case (size_fuse)
      2'h3: start = BOOT_START_256;
      2'h2: start = BOOT_START_512;
      2'h1: start = BOOT_START_1K;
      2'h0: start = BOOT_START_2K;
    endcase
    return start;
  endfunction
endpackage
